// ===== design/dtg_map.svh
// register offsets, field positions and reset values of the deadtime generator
`ifndef DTG_MAP_SVH
`define DTG_MAP_SVH
`define DTG_CTRL_OFFSET 4'h0
`define DTG_STATUS_OFFSET 4'h4
`define DTG_CTRL_SWEN_BIT 0
`define DTG_CTRL_RESET 1'h1
`define DTG_STATUS_HIGH_LSB 0
`define DTG_STATUS_LOW_LSB 3
`define DTG_STATUS_CMD_LSB 6
`define DTG_STATUS_BUSY_LSB 9
`define DTG_DEAD_CYCLES 8
`endif

// ===== design/dtg_pkg.sv
// shared types of the deadtime generator
package dtg_pkg;
   localparam int unsigned CHANNELS = 3;
   typedef logic [CHANNELS-1:0] dtg_phase_t;
   typedef enum logic [1:0] {
      DTG_REG_CTRL,
      DTG_REG_STATUS,
      DTG_REG_NONE
   } dtg_reg_t;
endpackage

// ===== design/dtg_deadtime_top.sv
// three-channel deadtime generator with a classic wishbone register slave
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "dtg_map.svh"
`default_nettype none
module dtg_deadtime_top #(
   parameter int unsigned DEAD_CYCLES = `DTG_DEAD_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,

   // phase commands from the pwm timer, asynchronous to mclk
   input wire logic phaseACmdIn,
   input wire logic phaseBCmdIn,
   input wire logic phaseCCmdIn,

   // enables gate the drives without waiting for a clock edge
   input wire logic phaseAEnable,
   input wire logic phaseBEnable,
   input wire logic phaseCEnable,
   input wire logic globalOutputEnable,

   // gate drive outputs, one pair per channel
   output logic phaseAHighDrive,
   output logic phaseALowDrive,
   output logic phaseBHighDrive,
   output logic phaseBLowDrive,
   output logic phaseCHighDrive,
   output logic phaseCLowDrive,

   // classic wishbone register slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o
);
   localparam int unsigned CH = dtg_pkg::CHANNELS;
   localparam int unsigned CW = (DEAD_CYCLES > 1) ? $clog2(DEAD_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(DEAD_CYCLES - 1);

   // elaboration checks: counter, pin map and status word only serve these values
   initial begin
      if (DEAD_CYCLES < 1 || DEAD_CYCLES > 256) begin
         $error("DEAD_CYCLES out of range");
      end
      if (CH != 3) begin
         $error("the pin map serves exactly three channels");
      end
      if (DEAD_CYCLES > (1 << CW)) begin
         $error("deadtime counter too narrow");
      end
      if (`DTG_STATUS_BUSY_LSB + CH > 32) begin
         $error("status fields exceed the bus width");
      end
      if (`DTG_STATUS_LOW_LSB < `DTG_STATUS_HIGH_LSB + CH) begin
         $error("status fields overlap");
      end
   end

   function automatic dtg_pkg::dtg_reg_t decodeReg(input logic [3:0] adr);
      if (adr == `DTG_CTRL_OFFSET) begin
         return dtg_pkg::DTG_REG_CTRL;
      end else if (adr == `DTG_STATUS_OFFSET) begin
         return dtg_pkg::DTG_REG_STATUS;
      end
      return dtg_pkg::DTG_REG_NONE;
   endfunction

   // no wrap is possible: the sequencer stops counting at LAST
   function automatic logic [CW-1:0] nextCount(input logic [CW-1:0] count);
      return count + CW'(1);
   endfunction

   // one gate for both drives keeps the high and low shutdown paths identical
   function automatic dtg_pkg::dtg_phase_t gateDrive(
      input dtg_pkg::dtg_phase_t on,
      input dtg_pkg::dtg_phase_t en,
      input logic gate
   );
      return on & en & {CH{gate}};
   endfunction

   function automatic logic [31:0] ctrlWord(input logic swEn);
      logic [31:0] w;
      w = '0;
      w[`DTG_CTRL_SWEN_BIT] = swEn;
      return w;
   endfunction

   function automatic logic [31:0] statusWord(
      input dtg_pkg::dtg_phase_t high,
      input dtg_pkg::dtg_phase_t low,
      input dtg_pkg::dtg_phase_t cmd,
      input dtg_pkg::dtg_phase_t busy
   );
      logic [31:0] w;
      w = '0;
      w[`DTG_STATUS_HIGH_LSB +: CH] = high;
      w[`DTG_STATUS_LOW_LSB +: CH] = low;
      w[`DTG_STATUS_CMD_LSB +: CH] = cmd;
      w[`DTG_STATUS_BUSY_LSB +: CH] = busy;
      return w;
   endfunction

   dtg_pkg::dtg_phase_t cmdPins;
   dtg_pkg::dtg_phase_t chEnable;
   dtg_pkg::dtg_phase_t cmdMeta_q;
   dtg_pkg::dtg_phase_t cmdSync_q;
   dtg_pkg::dtg_phase_t target_q;
   dtg_pkg::dtg_phase_t target_d;
   dtg_pkg::dtg_phase_t busy_q;
   dtg_pkg::dtg_phase_t busy_d;
   dtg_pkg::dtg_phase_t highOn_q;
   dtg_pkg::dtg_phase_t highOn_d;
   dtg_pkg::dtg_phase_t lowOn_q;
   dtg_pkg::dtg_phase_t lowOn_d;
   logic [CW-1:0] count_q [CH];
   logic [CW-1:0] count_d [CH];
   dtg_pkg::dtg_phase_t cmdChanged;
   dtg_pkg::dtg_phase_t countDone;

   dtg_pkg::dtg_phase_t highGated;
   dtg_pkg::dtg_phase_t lowGated;
   logic globalGate;

   logic swEnable_q;
   logic swEnable_d;
   logic ack_q;
   logic ack_d;
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic wbReq;
   logic wbWriteCtrl;
   dtg_pkg::dtg_reg_t wbTarget;

   assign cmdPins = {phaseCCmdIn, phaseBCmdIn, phaseACmdIn};
   assign chEnable = {phaseCEnable, phaseBEnable, phaseAEnable};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmdMeta_q <= '0;
         cmdSync_q <= '0;
      end else begin
         cmdMeta_q <= cmdPins;
         cmdSync_q <= cmdMeta_q;
      end
   end

   // change and terminal-count decode per channel
   always_comb begin
      cmdChanged = cmdSync_q ^ target_q;
      for (int i = 0; i < CH; i++) begin
         countDone[i] = (count_q[i] == LAST);
      end
   end

   // per-channel deadtime sequencer; a single counter width for all keeps deadtime equal
   always_comb begin
      target_d = target_q;
      busy_d = busy_q;
      highOn_d = highOn_q;
      lowOn_d = lowOn_q;

      for (int i = 0; i < CH; i++) begin
         count_d[i] = count_q[i];
         if (cmdChanged[i]) begin
            // glitches only ever extend the dead interval
            target_d[i] = cmdSync_q[i];
            busy_d[i] = 1'b1;
            count_d[i] = '0;
            highOn_d[i] = 1'b0;
            lowOn_d[i] = 1'b0;
         end else if (busy_q[i]) begin
            // complementary drive after the full count
            // same count for every channel and edge
            // eight periods of mclk by default
            if (countDone[i]) begin
               busy_d[i] = 1'b0;
               // high follows command, low its complement
               highOn_d[i] = target_q[i];
               lowOn_d[i] = ~target_q[i];
            end else begin
               count_d[i] = nextCount(count_q[i]);
            end
         end
      end
   end

   // reset clears both drives of every channel
   // reset leaves every channel mid-deadtime so alignment waits a full count
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         target_q <= '0;
         busy_q <= '1;
         highOn_q <= '0;
         lowOn_q <= '0;
         for (int i = 0; i < CH; i++) begin
            count_q[i] <= '0;
         end
      end else begin
         target_q <= target_d;
         busy_q <= busy_d;
         highOn_q <= highOn_d;
         lowOn_q <= lowOn_d;
         for (int i = 0; i < CH; i++) begin
            count_q[i] <= count_d[i];
         end
      end
   end

   // enables gate combinationally so a fault shutdown needs no clock edge
   // global enable gates all six drives
   assign globalGate = globalOutputEnable & swEnable_q & resetn;
   // both low while busy, since the on flags are cleared
   // channel enable gates its own pair
   // channel gate per pair, global gate for all
   // gating sits after the sequencer, which keeps running
   assign highGated = gateDrive(highOn_q, chEnable, globalGate);
   assign lowGated = gateDrive(lowOn_q, chEnable, globalGate);

   // pin map: bit 0 is phase a, bit 2 is phase c
   assign phaseAHighDrive = highGated[0];
   assign phaseALowDrive = lowGated[0];

   assign phaseBHighDrive = highGated[1];
   assign phaseBLowDrive = lowGated[1];

   assign phaseCHighDrive = highGated[2];
   assign phaseCLowDrive = lowGated[2];

   // wishbone slave: ack one cycle after the request, dropped the cycle after
   assign wbReq = cyc_i & stb_i & ~ack_q;
   assign wbTarget = decodeReg(adr_i);
   assign wbWriteCtrl = wbReq & we_i & sel_i[0] & (wbTarget == dtg_pkg::DTG_REG_CTRL);

   always_comb begin
      swEnable_d = swEnable_q;
      ack_d = 1'b0;
      rdData_d = rdData_q;
      if (wbWriteCtrl) begin
         swEnable_d = dat_i[`DTG_CTRL_SWEN_BIT];
      end
      if (wbReq) begin
         ack_d = 1'b1;
         unique case (wbTarget)
            dtg_pkg::DTG_REG_CTRL: begin
               rdData_d = ctrlWord(swEnable_q);
            end
            dtg_pkg::DTG_REG_STATUS: begin
               rdData_d = statusWord(highGated, lowGated, cmdSync_q, busy_q);
            end
            dtg_pkg::DTG_REG_NONE: begin
               rdData_d = '0;
            end
         endcase
      end
   end

   // software output enable; status reads show the gated pins, as the drivers see them
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         swEnable_q <= `DTG_CTRL_RESET;
      end else begin
         swEnable_q <= swEnable_d;
      end
   end

   // bus answer registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         rdData_q <= '0;
      end else begin
         ack_q <= ack_d;
         rdData_q <= rdData_d;
      end
   end

   // both bus outputs come straight from flops
   assign ack_o = ack_q;
   assign dat_o = rdData_q;
endmodule
`default_nettype wire

// ===== test/dtg_pwm_source.sv
// pwm timer stand-in driving the three phase command pins
`timescale 1ns/1ps
`default_nettype none
module dtg_pwm_source (
   input wire logic mclk,
   input wire logic [2:0] level,
   output logic [2:0] phaseCmd
);
   // a timer pin moves only just after its own clock edge
   always_ff @(posedge mclk) begin
      phaseCmd <= level;
   end
endmodule
`default_nettype wire

// ===== test/dtg_deadtime_assertions.sv
// concurrent checks on the deadtime generator pins
`timescale 1ns/1ps
`default_nettype none
module dtg_deadtime_checker (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic phaseACmdIn,
   input wire logic phaseAEnable,
   input wire logic globalOutputEnable,
   input wire logic phaseAHighDrive,
   input wire logic phaseALowDrive,
   input wire logic phaseBHighDrive,
   input wire logic phaseBLowDrive,
   input wire logic phaseCHighDrive,
   input wire logic phaseCLowDrive
);
   wire logic [2:0] hi = {phaseCHighDrive, phaseBHighDrive, phaseAHighDrive};
   wire logic [2:0] lo = {phaseCLowDrive, phaseBLowDrive, phaseALowDrive};
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // a quiet channel a: both drives off, command held low, gates open
   sequence sDeadA;
      (!hi[0] && !lo[0] && !phaseACmdIn && phaseAEnable && globalOutputEnable)[*8];
   endsequence
   a_no_shoot: assert property ((hi & lo) == 3'h0)
      else $error("drives overlap");
   a_global_off: assert property (!globalOutputEnable |-> (hi | lo) == 3'h0)
      else $error("global gate ignored");
   a_chan_off: assert property (!phaseAEnable |-> !hi[0] && !lo[0])
      else $error("channel gate ignored");
   a_turn_off: assert property ($fell(phaseACmdIn) |-> ##3 !hi[0])
      else $error("high drive not off");
   a_dead_span: assert property (hi[0] ##1 sDeadA |=> lo[0])
      else $error("low drive late");
   a_high_cmd: assert property (hi[0] |-> $past(phaseACmdIn, 3))
      else $error("high drive without command");
   a_low_cmd: assert property (lo[0] |-> !$past(phaseACmdIn, 3))
      else $error("low drive against command");
   a_reset_settle: assert property ($rose(resetn) |-> ((hi | lo) == 3'h0)[*8])
      else $error("drive before deadtime");
endmodule
bind dtg_deadtime_top dtg_deadtime_checker u_dtg_deadtime_checker (.mclk, .resetn, .phaseACmdIn, .phaseAEnable,
   .globalOutputEnable, .phaseAHighDrive, .phaseALowDrive, .phaseBHighDrive, .phaseBLowDrive, .phaseCHighDrive,
   .phaseCLowDrive);
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the deadtime generator
`timescale 1ns/1ps
`include "dtg_map.svh"
`default_nettype none
module tb_top;
   logic mclk, resetn, goe, cyc, stb, we;
   logic [2:0] lvl, en;
   logic [3:0] adr;
   logic [31:0] dat, q;
   wire logic ack;
   wire logic [2:0] cmd, hi, lo;
   wire logic [31:0] datO;
   int fail_count = 0;
   int num_checks = 0;
   dtg_pwm_source u_dtg_pwm_source (.mclk(mclk), .level(lvl), .phaseCmd(cmd));
   dtg_deadtime_top u_dtg_deadtime_top (.mclk(mclk), .resetn(resetn), .phaseACmdIn(cmd[0]), .phaseBCmdIn(cmd[1]),
      .phaseCCmdIn(cmd[2]), .phaseAEnable(en[0]), .phaseBEnable(en[1]), .phaseCEnable(en[2]),
      .globalOutputEnable(goe), .phaseAHighDrive(hi[0]), .phaseALowDrive(lo[0]), .phaseBHighDrive(hi[1]),
      .phaseBLowDrive(lo[1]), .phaseCHighDrive(hi[2]), .phaseCLowDrive(lo[2]), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(datO), .ack_o(ack));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      test_done;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // waits as long as the slave needs; only the watchdog ends a hung transfer
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
      do @(posedge mclk); while (ack !== 1'b1);
      q = datO;
      {cyc, stb} <= 2'h0;
   endtask
   // both-low cycles are counted over a fixed window; a revert r cycles in adds r
   task automatic xfer(input int c, input logic v, input int r);
      int n;
      n = 0;
      @(posedge mclk);
      lvl[c] <= v;
      if (r > 0) begin
         repeat (r) @(posedge mclk);
         lvl[c] <= !v;
      end
      repeat (30) begin
         @(negedge mclk);
         if (hi[c] === 1'b0 && lo[c] === 1'b0) n++;
      end
      chk(32'(n), 32'(r + `DTG_DEAD_CYCLES));
      chk({hi[c], lo[c]}, {v ^ (r > 0), !(v ^ (r > 0))});
   endtask
   initial begin
      {resetn, cyc, stb, we, adr, dat, lvl} = '0;
      {goe, en} = 4'hf;
      repeat (12) @(posedge mclk);
      chk({hi, lo}, 32'h0);
      resetn <= 1'b1;
      repeat (20) @(negedge mclk);
      chk({hi, lo}, 32'h7);
      for (int c = 0; c < 3; c++) begin
         xfer(c, 1'b1, 0);
         xfer(c, 1'b0, 0);
      end
      xfer(0, 1'b1, 3);
      xfer(1, 1'b1, 1);
      xfer(0, 1'b1, 0);
      $display("deadtime test done");
      @(posedge mclk);
      en[0] <= 1'b0;
      @(negedge mclk);
      chk({hi, lo}, 32'h6);
      @(posedge mclk);
      lvl[0] <= 1'b0;
      repeat (6) @(posedge mclk);
      en[0] <= 1'b1;
      @(negedge mclk);
      chk({hi[0], lo[0]}, 32'h0);
      repeat (8) @(negedge mclk);
      chk(lo, 32'h7);
      @(posedge mclk);
      goe <= 1'b0;
      @(negedge mclk);
      chk({hi, lo}, 32'h0);
      @(posedge mclk);
      goe <= 1'b1;
      $display("enable test done");
      wb(1'b0, 4'h0, 32'h0);
      chk(q, 32'h1);
      wb(1'b1, 4'h0, 32'h0);
      @(negedge mclk);
      chk({hi, lo}, 32'h0);
      wb(1'b0, 4'h4, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, 4'h0, 32'h1);
      wb(1'b0, 4'h4, 32'h0);
      chk(q, 32'h38);
      $display("register test done");
      test_done;
   end
endmodule
`default_nettype wire
